// >>> deser_regs_pkg.sv
// Purpose: shared constants and types of the shared status/config register bank
// Assumes: 20 MHz reference clock, two receive ports
// Notes:   offsets are the byte addresses of the serial control bus
package deser_regs_pkg;
   // =====================================================================
   // register offsets
   localparam logic [7:0] OFS_GEN_CFG  = 8'h02;
   localparam logic [7:0] OFS_REV      = 8'h03;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_THR_HI   = 8'h05;
   localparam logic [7:0] OFS_THR_LO   = 8'h06;
   localparam logic [7:0] OFS_WDOG     = 8'h07;
   localparam logic [7:0] OFS_I2C_CTL1 = 8'h08;
   // =====================================================================
   // field positions
   localparam int GEN_PAR_EN_BIT = 1;
   localparam int GEN_RSVD_BIT   = 0;
   localparam int STS_CKSUM_BIT  = 7;
   localparam int STS_INIT_BIT   = 6;
   localparam int STS_PASS_BIT   = 3;
   localparam int STS_LOCK_BIT   = 2;
   localparam int WDOG_OFF_BIT   = 0;
   localparam int WDOG_TMO_LSB   = 1;
   localparam int REV_ID_LSB     = 4;
   localparam int I2C_BLOCK_BIT  = 7;
   // =====================================================================
   // values after reset
   localparam logic       RST_PAR_EN   = 1'h1;
   localparam logic       RST_GEN_RSVD = 1'h0;
   localparam logic [7:0] RST_THR_HI   = 8'h01;
   localparam logic [7:0] RST_THR_LO   = 8'h00;
   localparam logic [6:0] RST_WDOG_TMO = 7'h7F;
   localparam logic       RST_WDOG_OFF = 1'h0;
   localparam logic       RST_BLOCK    = 1'h0;
   // =====================================================================
   // sizes and timing
   localparam int         NPORTS       = 2;
   localparam int         LINK_W       = 12;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam logic [6:0] I2C_DEV_ADDR = 7'h3D;
   localparam int         CLK_HZ       = 20000000;
   localparam int         WDOG_UNIT_MS = 2;
   localparam int         WDOG_UNIT_CYC = WDOG_UNIT_MS * (CLK_HZ / 1000);
   // =====================================================================
   // serial control engine states
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK} i2c_state_t;
endpackage : deser_regs_pkg

// >>> reg_port_if.sv
// Purpose: byte register port between serial control engine and register bank
// Assumes: both ends on the reference clock
// Notes:   wr and rd are one-cycle strobes
`timescale 1ns/1ps
interface reg_port_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       wr;
   logic       rd;
   modport engine (output addr, output wdata, output wr, output rd, input rdata);
   modport bank   (input addr, input wdata, input wr, input rd, output rdata);
endinterface : reg_port_if

// >>> i2c_reg_engine.sv
// Purpose: serial control bus slave turning bus bytes into register accesses
// Assumes: pins filtered by three flops; synchronous reset copy from the top
// Notes:   first written byte sets the pointer, later bytes auto-increment
`timescale 1ns/1ps
module i2c_reg_engine
   import deser_regs_pkg::*;
(
   input  logic       clk_i,
   input  logic       rst_b_i,
   input  logic       scl_i,
   input  logic       sda_i,
   output logic       sda_o,
   output logic       sda_oe_o,
   reg_port_if.engine rp
);
   logic [2:0] scl_s_q, sda_s_q;
   logic       scl_f_q, sda_f_q, scl_p_q, sda_p_q;
   logic       scl_rise, scl_fall, start, stop;
   i2c_state_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, ptr_q;
   logic       first_q, inc_q, nack_q, oe_q, wr_q, rd_q;

   // =====================================================================
   // pin synchronisers, a change counts once stages two and three agree
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_f_q <= 1'h1;
         sda_f_q <= 1'h1;
         scl_p_q <= 1'h1;
         sda_p_q <= 1'h1;
      end
      else
      begin
         scl_s_q <= {scl_s_q[1:0], scl_i};
         sda_s_q <= {sda_s_q[1:0], sda_i};
         if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end

   // bus events from filtered levels
   assign scl_rise = scl_f_q & ~scl_p_q;
   assign scl_fall = ~scl_f_q & scl_p_q;
   assign start    = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
   assign stop     = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

   // =====================================================================
   // protocol engine
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         first_q <= 1'h0;
         inc_q <= 1'h0;
         nack_q <= 1'h0;
         oe_q <= 1'h0;
         wr_q <= 1'h0;
         rd_q <= 1'h0;
      end
      else
      begin
         wr_q <= 1'h0;
         rd_q <= 1'h0;
         if (start)
         begin
            st_q <= ST_ADDR;
            cnt_q <= 4'h0;
            first_q <= 1'h1;
            oe_q <= 1'h0;
         end
         else if (stop)
         begin
            st_q <= ST_IDLE;
            oe_q <= 1'h0;
         end
         else if (scl_rise)
         begin
            if (st_q == ST_ADDR || st_q == ST_WR)
            begin
               sh_q <= {sh_q[6:0], sda_f_q};
               cnt_q <= cnt_q + 4'h1;
            end
            else if (st_q == ST_RD) cnt_q <= cnt_q + 4'h1;
            else if (st_q == ST_RACK) nack_q <= sda_f_q;
         end
         else if (scl_fall)
         begin
            unique case (st_q)
               ST_IDLE: ;
               ST_ADDR:
                  if (cnt_q == BYTE_BITS)
                  begin
                     if (sh_q[7:1] == I2C_DEV_ADDR)
                     begin
                        st_q <= ST_AACK;
                        oe_q <= 1'h1;
                     end
                     else st_q <= ST_IDLE;
                  end
               ST_AACK:
               begin
                  cnt_q <= 4'h0;
                  if (sh_q[0])
                  begin
                     st_q <= ST_RD;
                     sh_q <= rp.rdata;
                     rd_q <= 1'h1;
                     oe_q <= ~rp.rdata[7];
                  end
                  else
                  begin
                     st_q <= ST_WR;
                     oe_q <= 1'h0;
                  end
               end
               ST_WR:
                  if (cnt_q == BYTE_BITS)
                  begin
                     st_q <= ST_WACK;
                     oe_q <= 1'h1;
                     inc_q <= ~first_q;
                     first_q <= 1'h0;
                     if (first_q) ptr_q <= sh_q;
                     else wr_q <= 1'h1;
                  end
               ST_WACK:
               begin
                  st_q <= ST_WR;
                  cnt_q <= 4'h0;
                  oe_q <= 1'h0;
                  if (inc_q) ptr_q <= ptr_q + 8'h01;
               end
               ST_RD:
                  if (cnt_q == BYTE_BITS)
                  begin
                     st_q <= ST_RACK;
                     oe_q <= 1'h0;
                     ptr_q <= ptr_q + 8'h01;
                  end
                  else
                  begin
                     sh_q <= {sh_q[6:0], 1'h0};
                     oe_q <= ~sh_q[6];
                  end
               ST_RACK:
                  if (nack_q) st_q <= ST_IDLE;
                  else
                  begin
                     st_q <= ST_RD;
                     cnt_q <= 4'h0;
                     sh_q <= rp.rdata;
                     rd_q <= 1'h1;
                     oe_q <= ~rp.rdata[7];
                  end
            endcase
         end
      end
   end

   // open-drain pin and register port
   assign sda_o    = 1'h0;
   assign sda_oe_o = oe_q;
   assign rp.addr  = ptr_q;
   assign rp.wdata = sh_q;
   assign rp.wr    = wr_q;
   assign rp.rd    = rd_q;
endmodule : i2c_reg_engine

// >>> deser_shared_regs.sv
// Purpose: shared status and configuration registers of the deserializer
// Assumes: host on the serial control bus, receive data on the link clock
// Notes:   parity error events cross by toggle, enable crosses as a level
// Operation
// [R1] parity checking on received bits when enabled
// [R2] checksum status set after init if valid
// [R3] init done status after load completes
// [R4] pass status mirrors pin, latches high
// [R5] lock status mirrors pin, latches high
// [R6] threshold is high byte and low byte
// [R7] port fault when error count reaches threshold
// [R8] watchdog aborts side channel transaction at timeout
// [R9] host never programs timeout of zero
// [R10] disable bit stops the watchdog
// [R11] block bit rejects remote local register writes
// [R12] pass-through remote accesses unaffected by block
// [R13] latched bits return to live after read
`timescale 1ns/1ps
module deser_shared_regs
   import deser_regs_pkg::*;
#(
   parameter int         WDOG_UNIT_CYCLES = WDOG_UNIT_CYC,
   parameter logic [3:0] SILICON_REV      = 4'h5  // arbitrary value
)
(
   input  logic                          ref_clk_i,
   input  logic                          rst_b_i,
   input  logic                          scl_i,
   input  logic                          sda_i,
   output logic                          sda_o,
   output logic                          sda_oe_o,
   input  logic                          link_clk_i,
   input  logic [NPORTS-1:0]             link_valid_i,
   input  logic [NPORTS-1:0][LINK_W:0]   link_word_i,
   input  logic                          cfg_init_done_i,
   input  logic                          cfg_cksum_valid_i,
   input  logic                          pass_ind_i,
   input  logic                          lock_ind_i,
   input  logic [NPORTS-1:0]             parity_count_clr_i,
   output logic [NPORTS-1:0]             parity_fault_o,
   input  logic                          bcc_busy_i,
   output logic                          bcc_abort_o,
   input  logic                          remote_wr_i,
   input  logic                          remote_local_i,
   input  logic [7:0]                    remote_addr_i,
   input  logic [7:0]                    remote_wdata_i,
   output logic                          remote_pass_o,
   output logic                          remote_reject_o
);
   logic [1:0]  rst_s_q, link_rst_q;
   logic        rst_b, link_rst_b;
   logic        par_en_q, gen_rsvd_q, block_q, wdog_off_q;
   logic [6:0]  wdog_tmo_q;
   logic [7:0]  thr_hi_q, thr_lo_q;
   logic [15:0] thr;
   logic        init_q, cksum_q, pass_q, lock_q, status_rd;
   logic        w_en, remote_ok;
   logic [7:0]  w_addr, w_data, rdata_q;
   logic [1:0]  en_l_q;
   logic [NPORTS-1:0] tog_l_q;
   logic [15:0] tick_q;
   logic [6:0]  unit_q;
   logic        fired_q, abort_q, pass_q2, reject_q;
   reg_port_if  bus ();

   // =====================================================================
   // reset release, one copy per clock domain
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i) rst_s_q <= 2'h0;
      else rst_s_q <= {rst_s_q[0], 1'h1};
   end
   always_ff @(posedge link_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i) link_rst_q <= 2'h0;
      else link_rst_q <= {link_rst_q[0], 1'h1};
   end
   assign rst_b      = rst_s_q[1];
   assign link_rst_b = link_rst_q[1];

   // =====================================================================
   // serial control bus slave
   i2c_reg_engine u_engine (
      .clk_i    (ref_clk_i),
      .rst_b_i  (rst_b),
      .scl_i    (scl_i),
      .sda_i    (sda_i),
      .sda_o    (sda_o),
      .sda_oe_o (sda_oe_o),
      .rp       (bus.engine)
   );

   // write decode shared by every writable register
   function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] t);
      return en && (a == t);
   endfunction : hit

   // =====================================================================
   // write source select, host bus first
   assign remote_ok = remote_wr_i & remote_local_i & ~block_q & ~bus.wr;  // R11
   assign w_en      = bus.wr | remote_ok;
   assign w_addr    = bus.wr ? bus.addr : remote_addr_i;
   assign w_data    = bus.wr ? bus.wdata : remote_wdata_i;

   // remote outcome strobes, pass-through never gated by block
   always_ff @(posedge ref_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pass_q2 <= 1'h0;
         reject_q <= 1'h0;
      end
      else
      begin
         pass_q2 <= remote_wr_i & ~remote_local_i;  // R12
         reject_q <= remote_wr_i & remote_local_i & (block_q | bus.wr);  // R11
      end
   end
   assign remote_pass_o   = pass_q2;
   assign remote_reject_o = reject_q;

   // =====================================================================
   // writable registers
   always_ff @(posedge ref_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         par_en_q <= RST_PAR_EN;
         gen_rsvd_q <= RST_GEN_RSVD;
         thr_hi_q <= RST_THR_HI;
         thr_lo_q <= RST_THR_LO;
         wdog_tmo_q <= RST_WDOG_TMO;
         wdog_off_q <= RST_WDOG_OFF;
         block_q <= RST_BLOCK;
      end
      else
      begin
         if (hit(w_en, w_addr, OFS_GEN_CFG))
         begin
            par_en_q <= w_data[GEN_PAR_EN_BIT];  // R1
            gen_rsvd_q <= w_data[GEN_RSVD_BIT];
         end
         if (hit(w_en, w_addr, OFS_THR_HI)) thr_hi_q <= w_data;  // R6
         if (hit(w_en, w_addr, OFS_THR_LO)) thr_lo_q <= w_data;  // R6
         if (hit(w_en, w_addr, OFS_WDOG))
         begin
            wdog_tmo_q <= w_data[7:WDOG_TMO_LSB];  // R8
            wdog_off_q <= w_data[WDOG_OFF_BIT];  // R10
         end
         if (hit(w_en, w_addr, OFS_I2C_CTL1)) block_q <= w_data[I2C_BLOCK_BIT];  // R11
      end
   end
   assign thr = {thr_hi_q, thr_lo_q};  // R6

   // =====================================================================
   // device status, latched bits fall back to live value after a read
   assign status_rd = bus.rd && (bus.addr == OFS_STATUS);
   always_ff @(posedge ref_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         init_q <= 1'h0;
         cksum_q <= 1'h0;
         pass_q <= 1'h0;
         lock_q <= 1'h0;
      end
      else
      begin
         init_q <= cfg_init_done_i;  // R3
         cksum_q <= cfg_init_done_i & cfg_cksum_valid_i;  // R2
         pass_q <= pass_ind_i | (pass_q & ~status_rd);  // R4 R13
         lock_q <= lock_ind_i | (lock_q & ~status_rd);  // R5 R13
      end
   end

   // =====================================================================
   // read data register, unmapped offsets read zero
   always_ff @(posedge ref_clk_i or negedge rst_b)
   begin
      if (!rst_b) rdata_q <= 8'h00;
      else
      begin
         rdata_q <= 8'h00;
         unique case (bus.addr)
            OFS_GEN_CFG:
            begin
               rdata_q[GEN_PAR_EN_BIT] <= par_en_q;
               rdata_q[GEN_RSVD_BIT] <= gen_rsvd_q;
            end
            OFS_REV:      rdata_q[7:REV_ID_LSB] <= SILICON_REV;
            OFS_STATUS:
            begin
               rdata_q[STS_CKSUM_BIT] <= cksum_q;  // R2
               rdata_q[STS_INIT_BIT] <= init_q;  // R3
               rdata_q[STS_PASS_BIT] <= pass_q;  // R4
               rdata_q[STS_LOCK_BIT] <= lock_q;  // R5
            end
            OFS_THR_HI:   rdata_q <= thr_hi_q;
            OFS_THR_LO:   rdata_q <= thr_lo_q;
            OFS_WDOG:     rdata_q <= {wdog_tmo_q, wdog_off_q};
            OFS_I2C_CTL1: rdata_q[I2C_BLOCK_BIT] <= block_q;
            default:      rdata_q <= 8'h00;
         endcase
      end
   end
   assign bus.rdata = rdata_q;

   // =====================================================================
   // link domain: enable level in, parity error toggles out
   always_ff @(posedge link_clk_i or negedge link_rst_b)
   begin
      if (!link_rst_b) en_l_q <= 2'h0;
      else en_l_q <= {en_l_q[0], par_en_q};
   end
   always_ff @(posedge link_clk_i or negedge link_rst_b)
   begin
      if (!link_rst_b) tog_l_q <= '0;
      else
      begin
         for (int p = 0; p < NPORTS; p++)
            if (en_l_q[1] && link_valid_i[p] && (^link_word_i[p])) tog_l_q[p] <= ~tog_l_q[p];  // R1
      end
   end

   // =====================================================================
   // per-port error counting and fault compare on the reference clock
   generate
      for (genvar p = 0; p < NPORTS; p++)
      begin : g_port
         logic [2:0]  tog_s_q;
         logic        tog_f_q, fault_q, err;
         logic [15:0] cnt_q;
         assign err = (tog_s_q[1] == tog_s_q[2]) && (tog_s_q[2] != tog_f_q);
         always_ff @(posedge ref_clk_i or negedge rst_b)
         begin
            if (!rst_b)
            begin
               tog_s_q <= 3'h0;
               tog_f_q <= 1'h0;
               cnt_q <= 16'h0000;
               fault_q <= 1'h0;
            end
            else
            begin
               tog_s_q <= {tog_s_q[1:0], tog_l_q[p]};
               if (err) tog_f_q <= tog_s_q[2];
               // clear then count, so an error in the clear cycle survives
               if (parity_count_clr_i[p]) cnt_q <= {15'h0000, err};
               else if (err && cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
               fault_q <= (cnt_q >= thr);  // R7
            end
         end
         assign parity_fault_o[p] = fault_q;
      end
   endgenerate

   // =====================================================================
   // side channel watchdog, timeout in whole units of two milliseconds
   always_ff @(posedge ref_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tick_q <= 16'h0000;
         unit_q <= 7'h00;
         fired_q <= 1'h0;
         abort_q <= 1'h0;
      end
      else
      begin
         abort_q <= 1'h0;
         if (!bcc_busy_i || wdog_off_q)  // R10
         begin
            tick_q <= 16'h0000;
            unit_q <= 7'h00;
            fired_q <= 1'h0;
         end
         else if (!fired_q)
         begin
            if (tick_q == 16'(WDOG_UNIT_CYCLES - 1))
            begin
               tick_q <= 16'h0000;
               // a zero field would wrap to the full range
               if (unit_q + 7'h01 == wdog_tmo_q)  // R8 R9
               begin
                  fired_q <= 1'h1;
                  abort_q <= 1'h1;
               end
               else unit_q <= unit_q + 7'h01;
            end
            else tick_q <= tick_q + 16'h0001;
         end
      end
   end
   assign bcc_abort_o = abort_q;

   // =====================================================================
   // checks
   sequence s_status_read;
      status_rd;
   endsequence
   sequence s_blocked_write;
      remote_wr_i && remote_local_i && block_q && !bus.wr;
   endsequence

   a_parity_gate: assert property (  // R1
      @(posedge link_clk_i) disable iff (!link_rst_b) !en_l_q[1] |=> $stable(tog_l_q))
      else $error("parity event while checking off");
   a_cksum_status: assert property (@(posedge ref_clk_i) disable iff (!rst_b)  // R2
      (cfg_init_done_i && cfg_cksum_valid_i) ##1 !status_rd |=>
      rdata_q[STS_CKSUM_BIT] || $past(bus.addr) != OFS_STATUS)
      else $error("checksum status not shown");
   a_init_status: assert property (@(posedge ref_clk_i) disable iff (!rst_b)  // R3
      !cfg_init_done_i |=> !init_q ##1
      (!rdata_q[STS_INIT_BIT] || $past(bus.addr) != OFS_STATUS || $past(cfg_init_done_i)))
      else $error("init done shown early");
   a_pass_latch: assert property (  // R4
      @(posedge ref_clk_i) disable iff (!rst_b) pass_ind_i ##1 !status_rd [*3] |=> pass_q)
      else $error("pass latch lost without read");
   a_lock_latch: assert property (  // R5
      @(posedge ref_clk_i) disable iff (!rst_b) $rose(lock_ind_i) |=> lock_q ##1 (lock_q || $past(status_rd)))
      else $error("lock latch did not hold");
   a_thr_write: assert property (  // R6
      @(posedge ref_clk_i) disable iff (!rst_b) hit(w_en, w_addr, OFS_THR_HI) |=> thr[15:8] == $past(w_data))
      else $error("threshold high byte not written");
   a_fault_compare: assert property (  // R7
      @(posedge ref_clk_i) disable iff (!rst_b) (g_port[0].cnt_q >= thr) |=> parity_fault_o[0])
      else $error("parity fault not raised at threshold");
   a_abort_busy: assert property (@(posedge ref_clk_i) disable iff (!rst_b)  // R8
      bcc_abort_o |-> $past(bcc_busy_i) && $past(tick_q) == 16'(WDOG_UNIT_CYCLES - 1))
      else $error("abort without timed transaction");
   a_wdog_off: assert property (  // R10
      @(posedge ref_clk_i) disable iff (!rst_b) wdog_off_q |=> !bcc_abort_o && tick_q == 16'h0000)
      else $error("watchdog ran while disabled");
   a_remote_block: assert property (@(posedge ref_clk_i) disable iff (!rst_b)  // R11
      s_blocked_write |=> $stable(thr) && $stable(wdog_tmo_q) && remote_reject_o)
      else $error("blocked remote write took effect");
   a_pass_through: assert property (  // R12
      @(posedge ref_clk_i) disable iff (!rst_b) remote_wr_i && !remote_local_i && block_q |=> remote_pass_o)
      else $error("pass-through access gated by block");
   a_read_release: assert property (  // R13
      @(posedge ref_clk_i) disable iff (!rst_b) s_status_read ##0 !pass_ind_i |=> !pass_q)
      else $error("pass latch kept after read");
endmodule : deser_shared_regs

// >>> i2c_host_model.sv
// Purpose: host model on the serial control bus
// Assumes: open-drain data wire resolved in the bench
// Notes:   pull_o high pulls data low; nak latches high on any missed ack
`timescale 1ns/1ps
module i2c_host_model
   import deser_regs_pkg::*;
(
   input  logic sda_i,
   output logic scl_o,
   output logic pull_o
);
   localparam time H = 500ns;
   logic [7:0] q;
   logic       nak = 1'b0;
   // bus idle
   initial
   begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   // one bit: data set mid-low, sampled at end of high
   task automatic bt(input logic d, output logic r);
      #(H/2) pull_o = ~d;
      #(H/2) scl_o = 1'b1;
      #H r = sda_i;
      scl_o = 1'b0;
   endtask : bt
   // byte then ack slot, released so the device may ack
   task automatic by(input logic [7:0] d, input logic rd);
      logic a;
      for (int i = 7; i >= 0; i--)
         bt(d[i], q[i]);
      bt(1'b1, a);
      if (!rd)
         nak = nak | a;
   endtask : by
   // start or repeated start
   task automatic st();
      #(H/2) pull_o = 1'b0;
      #(H/2) scl_o = 1'b1;
      #H pull_o = 1'b1;
      #H scl_o = 1'b0;
   endtask : st
   // stop
   task automatic sp();
      #(H/2) pull_o = 1'b1;
      #(H/2) scl_o = 1'b1;
      #H pull_o = 1'b0;
      #H;
   endtask : sp
   // register write: pointer byte then data
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      st();
      by({I2C_DEV_ADDR, 1'b0}, 1'b0);
      by(o, 1'b0);
      by(d, 1'b0);
      sp();
   endtask : wr
   // register read: set pointer, repeated start, one byte
   task automatic rd(input logic [7:0] o, output logic [7:0] d);
      st();
      by({I2C_DEV_ADDR, 1'b0}, 1'b0);
      by(o, 1'b0);
      st();
      by({I2C_DEV_ADDR, 1'b1}, 1'b0);
      by(8'hFF, 1'b1);
      d = q;
      sp();
   endtask : rd
endmodule : i2c_host_model

// >>> tb_top.sv
// Purpose: self-checking bench of the shared register bank
// Assumes: watchdog unit shortened to 20 cycles
// Notes:   table rows first, then hand-written cases
`timescale 1ns/1ps
`define CK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module tb_top
   import deser_regs_pkg::*;
;
   typedef struct {logic [7:0] o, rv, w, e;} row_t;
   logic clk = 1'b0, lck = 1'b0, rst_b = 1'b0, busy = 1'b0, rw = 1'b0, loc = 1'b0;
   logic [1:0] vld = 2'h0, clr = 2'h0, pl = 2'h0, cf = 2'h3, flt;
   logic [1:0][12:0] wd = {13'h0001, 13'h0001};
   logic scl, pull, oe, sdo, sda, abrt, pas, rej;
   logic [7:0] r;
   int error_cnt = 0, checks_done = 0, n;
   row_t rows[8] = '{'{8'h02, 8'h02, 8'hFF, 8'h03}, '{8'h03, 8'h50, 8'hFF, 8'h50},
      '{8'h04, 8'hC0, 8'hFF, 8'hC0}, '{8'h05, 8'h01, 8'h00, 8'h00}, '{8'h06, 8'h00, 8'h03, 8'h03},
      '{8'h07, 8'hFE, 8'h04, 8'h04}, '{8'h08, 8'h00, 8'hFF, 8'h80}, '{8'h0F, 8'h00, 8'hFF, 8'h00}};
   // clocks and open-drain wire
   assign sda = ~((oe & ~sdo) | pull);
   always #25 clk = ~clk;
   always #62.5 lck = ~lck;
   deser_shared_regs #(.WDOG_UNIT_CYCLES(20), .SILICON_REV(4'h5)) dut (.ref_clk_i(clk), .rst_b_i(rst_b),
      .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .link_clk_i(lck), .link_valid_i(vld),
      .link_word_i(wd), .cfg_init_done_i(cf[1]), .cfg_cksum_valid_i(cf[0]), .pass_ind_i(pl[1]),
      .lock_ind_i(pl[0]), .parity_count_clr_i(clr), .parity_fault_o(flt), .bcc_busy_i(busy),
      .bcc_abort_o(abrt), .remote_wr_i(rw), .remote_local_i(loc), .remote_addr_i(8'h06),
      .remote_wdata_i(8'h02), .remote_pass_o(pas), .remote_reject_o(rej));
   i2c_host_model host (.sda_i(sda), .scl_o(scl), .pull_o(pull));
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #5;
   endtask : cyc
   task automatic rc(input logic [7:0] o, input logic [7:0] e);
      host.rd(o, r);
      `CK(r, e)
   endtask : rc
   // remote write strobe, reject and pass seen one cycle later
   task automatic rm(input logic l, input logic [1:0] e);
      cyc(1);
      rw = 1'b1;
      loc = l;
      cyc(1);
      rw = 1'b0;
      `CK({rej, pas}, e)
   endtask : rm
   // error words on the link for k link cycles
   task automatic lk(input logic [1:0] v, input int k);
      @(posedge lck);
      #5 vld = v;
      repeat (k) @(posedge lck);
      #5 vld = 2'h0;
      cyc(12);
   endtask : lk
   // hang guard
   initial
   begin
      #4ms;
      error_cnt++;
      end_sim();
   end
   // main sequence
   initial
   begin
      cyc(5);
      rst_b = 1'b1;
      cyc(6);
      foreach (rows[i])
      begin
         rc(rows[i].o, rows[i].rv);
         host.wr(rows[i].o, rows[i].w);
         rc(rows[i].o, rows[i].e);
      end
      cf = 2'h1;
      rc(8'h04, 8'h00);
      cf = 2'h2;
      rc(8'h04, 8'h40);
      cf = 2'h3;
      pl = 2'h3;
      cyc(1);
      pl = 2'h0;
      rc(8'h04, 8'hCC);
      rc(8'h04, 8'hC0);
      rm(1'b1, 2'h2);
      rm(1'b0, 2'h1);
      rc(8'h06, 8'h03);
      host.wr(8'h08, 8'h00);
      rm(1'b1, 2'h0);
      rc(8'h06, 8'h02);
      lk(2'h3, 1);
      `CK(flt, 2'h0)
      lk(2'h1, 1);
      `CK(flt, 2'h1)
      host.wr(8'h02, 8'h00);
      clr = 2'h3;
      cyc(1);
      clr = 2'h0;
      lk(2'h3, 4);
      `CK(flt, 2'h0)
      busy = 1'b1;
      n = 0;
      while (abrt !== 1'b1 && n < 60)
      begin
         cyc(1);
         n++;
      end
      `CK(n inside {[40:42]}, 1'b1)
      busy = 1'b0;
      host.wr(8'h07, 8'h05);
      busy = 1'b1;
      n = 0;
      repeat (100)
      begin
         cyc(1);
         n += int'(abrt !== 1'b0);
      end
      `CK(n, 0)
      busy = 1'b0;
      rst_b = 1'b0;
      cyc(5);
      rst_b = 1'b1;
      cyc(6);
      rc(8'h05, 8'h01);
      rc(8'h07, 8'hFE);
      `CK(host.nak, 1'b0)
      end_sim();
   end
endmodule : tb_top
